// file: logic/filt_vlan_stat_pkg.sv
// Package for the filter, VLAN protocol and serial link status register bank.
// Assumes one 32-bit word per register on a plain strobe port.
package filt_vlan_stat_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Byte offsets of the registers in this bank
  localparam logic [11:0] OFF_UNICAST_ADDR_UPPER = 12'h024;
  localparam logic [11:0] OFF_VLAN_TAG_PROTO_WORD0 = 12'h028;
  localparam logic [11:0] OFF_VLAN_TAG_PROTO_WORD1 = 12'h02c;
  localparam logic [11:0] OFF_SERIAL_LINK_STATUS = 12'h030;
  // Lower unicast word, needed to form the full match address
  localparam logic [11:0] OFF_UNICAST_ADDR_LOWER = 12'h020;

  // Reset values
  localparam logic [15:0] RST_UNICAST_UPPER = 16'h0000;
  localparam logic [31:0] RST_UNICAST_LOWER = 32'h0000_0000;
  localparam logic [15:0] RST_TPID = 16'h0000;

  // Field positions of the serial link status word
  localparam int POS_REMOTE_FAULT = 13;
  localparam int POS_DUPLEX = 12;
  localparam int POS_SPEED_LO = 10;
  localparam int POS_FAULT_CODE_LO = 8;
  localparam int POS_PHY_LINK = 7;
  localparam int POS_UNKNOWN_CG = 6;
  localparam int POS_DISP_ERR = 5;

  // Speed encodings
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_10 = 2'h0;

  // Physical interface kinds that make the status word live
  localparam int PHY_KIND_SGMII = 4;
  localparam int PHY_KIND_BASEX = 5;

  // Live status inputs from the serial PCS
  typedef struct packed {
    logic remote_fault_event;
    logic [1:0] remote_fault_code;
    logic full_duplex;
    logic [1:0] speed;
    logic external_phy_link_up;
    logic rx_unknown_code_group;
    logic rx_running_disparity_error;
  } pcs_status_t;

  // Received frame destination probe
  typedef struct packed {
    logic valid;
    logic is_unicast;
    logic [47:0] dest_addr;
  } rx_dest_t;

endpackage

// file: logic/filt_vlan_stat_regs.sv
// Register bank: upper unicast match word, four VLAN tag protocol identifiers,
// serial link status, plus the unicast drop decision that uses the address.
// Assumes pcs_status arrives from logic on the same clock; mgmt_status_read
// pulses for one cycle when the management interface reads PHY status reg 1.
//
// Notes on behaviour
// R1 - Upper unicast word only affects frames when extended multicast filter is built.
// R2 - Software must put the address filter into promiscuous mode when using it.
// R3 - Drop received unicast frames whose destination differs from programmed address.
// R4 - Upper word: bits 15..0 read-write reset zero, bits 31..16 read zero.
// R5 - First wire byte of the address sits in the lowest register byte.
// R6 - Four 16-bit protocol identifiers serve both transmit and receive tag matching.
// R7 - Word 0 holds identifier 1 high, identifier 0 low, reset zero.
// R8 - Word 1 holds identifier 3 high, identifier 2 low, reset zero.
// R9 - Identifiers used only when a tag insert, strip or translate function is built.
// R10 - Status is live only for tri-mode MAC with SGMII or 1000BASE-X, else zero.
// R11 - Bit 13 flags a remote fault in 1000BASE-X; bits 9..8 give its kind.
// R12 - Remote fault flag holds until management reads PHY status 1; void in SGMII.
// R13 - Bit 12 shows negotiated duplex, one meaning full.
// R14 - Bits 11..10 give negotiated speed: 10 gigabit, 01 hundred, 00 ten.
// R15 - Bits 9..8 carry remote fault encoding, 1000BASE-X only.
// R16 - Bit 7 shows external PHY link in SGMII, stays low in 1000BASE-X.
// R17 - Bit 6 flags a code group missing from the 8B/10B tables.
// R18 - Bit 5 flags a running disparity error in 8B/10B decoding.
// R19 - Status bits 31..14 are read-only zero.
// R20 - Writes to reserved or read-only bits do nothing; they read zero.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module filt_vlan_stat_regs
  import filt_vlan_stat_pkg::*;
#(
  parameter bit build_ext_multicast_filter = 1'b1,
  parameter bit build_tx_tag_insert = 1'b1,
  parameter bit build_rx_tag_insert = 1'b0,
  parameter bit build_tx_tag_strip = 1'b0,
  parameter bit build_rx_tag_strip = 1'b0,
  parameter bit build_tx_tag_translate = 1'b0,
  parameter bit build_rx_tag_translate = 1'b0,
  parameter bit build_tri_mode_mac = 1'b1,
  parameter int build_phy_interface_kind = 5
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire pcs_status_t pcs_status,
  input wire logic mgmt_status_read,
  input wire rx_dest_t rx_dest,
  output logic rx_drop,
  output logic [47:0] unicast_match_address,
  output logic [63:0] tag_proto_ids,
  output logic tag_proto_ids_valid
);

  // Build-time decisions
  localparam bit vlan_built = build_tx_tag_insert | build_rx_tag_insert |
    build_tx_tag_strip | build_rx_tag_strip | build_tx_tag_translate |
    build_rx_tag_translate;
  localparam bit status_live = build_tri_mode_mac &&
    (build_phy_interface_kind == PHY_KIND_SGMII ||
     build_phy_interface_kind == PHY_KIND_BASEX);
  localparam bit is_basex = (build_phy_interface_kind == PHY_KIND_BASEX);

  logic [31:0] unicast_lower_r;
  logic [15:0] unicast_upper_r;
  logic [15:0] vlan_tag_proto_word0_r;
  logic [15:0] vlan_tag_proto_word1_r;
  logic [15:0] tpid2_r;
  logic [15:0] tpid3_r;
  logic remote_fault_r;
  logic [31:0] status_r;
  logic [31:0] rdata_r;
  logic drop_r;
  logic [47:0] match_r;
  logic [63:0] tpids_r;
  logic ids_valid_r;

  // Write decode
  wire logic wr_lower = wr && addr == OFF_UNICAST_ADDR_LOWER;
  wire logic wr_upper = wr && addr == OFF_UNICAST_ADDR_UPPER;
  wire logic wr_tpw0 = wr && addr == OFF_VLAN_TAG_PROTO_WORD0;
  wire logic wr_tpw1 = wr && addr == OFF_VLAN_TAG_PROTO_WORD1;

  // Full 48-bit address: lowest register byte is the first wire byte
  wire logic [47:0] full_addr = {unicast_upper_r, unicast_lower_r}; // see R5

  // Remote fault: a new event wins over the clearing read
  wire logic fault_event = status_live && is_basex && pcs_status.remote_fault_event;
  wire logic remote_fault_nxt = fault_event ? 1'b1 :
    (mgmt_status_read ? 1'b0 : remote_fault_r); // see R12

  // Assemble the status word from live inputs
  logic [31:0] status_nxt;
  always_comb
  begin
    status_nxt = 32'h0000_0000; // see R19
    if (status_live) // see R10
    begin
      status_nxt[POS_REMOTE_FAULT] = remote_fault_nxt; // see R11
      status_nxt[POS_DUPLEX] = pcs_status.full_duplex; // see R13
      status_nxt[POS_SPEED_LO +: 2] = pcs_status.speed; // see R14
      status_nxt[POS_FAULT_CODE_LO +: 2] = is_basex ?
        pcs_status.remote_fault_code : 2'h0; // see R15
      status_nxt[POS_PHY_LINK] = is_basex ? 1'b0 :
        pcs_status.external_phy_link_up; // see R16
      status_nxt[POS_UNKNOWN_CG] = pcs_status.rx_unknown_code_group; // see R17
      status_nxt[POS_DISP_ERR] = pcs_status.rx_running_disparity_error; // see R18
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  wire logic [31:0] rd_mux =
    addr == OFF_UNICAST_ADDR_LOWER ? unicast_lower_r :
    addr == OFF_UNICAST_ADDR_UPPER ? {16'h0000, unicast_upper_r} : // see R4
    addr == OFF_VLAN_TAG_PROTO_WORD0 ? {vlan_tag_proto_word1_r, vlan_tag_proto_word0_r} : // see R7
    addr == OFF_VLAN_TAG_PROTO_WORD1 ? {tpid3_r, tpid2_r} : // see R8
    addr == OFF_SERIAL_LINK_STATUS ? status_r : 32'h0000_0000; // see R20

  // Unicast drop: only with the filter built; multicast passes to other logic
  wire logic drop_nxt = build_ext_multicast_filter && rx_dest.valid &&
    rx_dest.is_unicast && rx_dest.dest_addr != full_addr; // see R1 R3

  // Address registers; upper half of upper word is never stored
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      unicast_lower_r <= RST_UNICAST_LOWER;
      unicast_upper_r <= RST_UNICAST_UPPER;
    end
    else
    begin
      if (wr_lower)
        unicast_lower_r <= wdata;
      if (wr_upper)
        unicast_upper_r <= wdata[15:0]; // see R4 R20
    end
  end

  // Protocol identifier registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      vlan_tag_proto_word0_r <= RST_TPID;
      vlan_tag_proto_word1_r <= RST_TPID;
      tpid2_r <= RST_TPID;
      tpid3_r <= RST_TPID;
    end
    else
    begin
      if (wr_tpw0)
      begin
        vlan_tag_proto_word0_r <= wdata[15:0]; // see R7
        vlan_tag_proto_word1_r <= wdata[31:16];
      end
      if (wr_tpw1)
      begin
        tpid2_r <= wdata[15:0]; // see R8
        tpid3_r <= wdata[31:16];
      end
    end
  end

  // Status and sticky fault; the status word is read-only to software
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      remote_fault_r <= 1'b0;
      status_r <= 32'h0000_0000;
    end
    else
    begin
      remote_fault_r <= remote_fault_nxt;
      status_r <= status_nxt;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock)
  begin
    if (srst)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
  end

  // Registered datapath outputs; identifiers gated off when no VLAN function
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      drop_r <= 1'b0;
      match_r <= 48'h0000_0000_0000;
      tpids_r <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      drop_r <= drop_nxt;
      match_r <= build_ext_multicast_filter ? full_addr : 48'h0000_0000_0000; // see R1
      tpids_r <= vlan_built ? {tpid3_r, tpid2_r, vlan_tag_proto_word1_r, vlan_tag_proto_word0_r} :
        64'h0000_0000_0000_0000; // see R6 R9
    end
  end

  // Build flag for the identifier bus; registered so every output leaves a flop.
  // It reads zero during reset, so consumers must not trust the ids before release.
  always_ff @(posedge clock)
  begin
    if (srst)
      ids_valid_r <= 1'b0;
    else
      ids_valid_r <= vlan_built; // see R9
  end

  assign rdata = rdata_r;
  assign rx_drop = drop_r;
  assign unicast_match_address = match_r;
  assign tag_proto_ids = tpids_r;
  assign tag_proto_ids_valid = ids_valid_r;

  // Read of upper word shows zero in the reserved upper half one cycle later
  chk_upper_reserved: assert property (@(posedge clock) disable iff (srst)
    rd && addr == OFF_UNICAST_ADDR_UPPER |=> rdata[31:16] == 16'h0000) // see R4
    else $error("upper word reserved half not zero");

  chk_tpid_word0: assert property (@(posedge clock) disable iff (srst)
    wr_tpw0 |=> {vlan_tag_proto_word1_r, vlan_tag_proto_word0_r} == $past(wdata)) // see R7
    else $error("tpid word 0 not stored");

  chk_tpid_word1: assert property (@(posedge clock) disable iff (srst)
    wr_tpw1 |=> {tpid3_r, tpid2_r} == $past(wdata)) // see R8
    else $error("tpid word 1 not stored");

  chk_status_reserved: assert property (@(posedge clock) disable iff (srst)
    status_r[31:14] == 18'h0_0000 && status_r[4:0] == 5'h00) // see R19
    else $error("status reserved bits set");

  chk_fault_sticky: assert property (@(posedge clock) disable iff (srst)
    remote_fault_r && !mgmt_status_read |=> remote_fault_r) // see R12
    else $error("remote fault flag dropped early");

  chk_fault_set: assert property (@(posedge clock) disable iff (srst)
    fault_event |=> status_r[POS_REMOTE_FAULT] && remote_fault_r) // see R11
    else $error("remote fault not reported");

  chk_drop_mismatch: assert property (@(posedge clock) disable iff (srst)
    rx_dest.valid && rx_dest.is_unicast && build_ext_multicast_filter
    |=> rx_drop == ($past(rx_dest.dest_addr) != $past(full_addr))) // see R3
    else $error("unicast drop decision wrong");

  chk_speed_field: assert property (@(posedge clock) disable iff (srst)
    status_live |=> status_r[POS_SPEED_LO +: 2] == $past(pcs_status.speed)) // see R14
    else $error("speed field not tracking");

  chk_phy_link: assert property (@(posedge clock) disable iff (srst)
    is_basex |=> !status_r[POS_PHY_LINK]) // see R16
    else $error("phy link bit high in 1000BASE-X");

  chk_read_window: assert property (@(posedge clock) disable iff (srst)
    !rd |=> rdata == 32'h0000_0000) // see R20
    else $error("read data outside read cycle");

  // Low half of the upper word takes the written bits
  chk_upper_store: assert property (@(posedge clock) disable iff (srst)
    wr_upper |=> unicast_upper_r == $past(wdata[15:0])) // see R4
    else $error("upper word not stored");

  // Lower word is stored whole; it forms the first four wire bytes
  chk_lower_store: assert property (@(posedge clock) disable iff (srst)
    wr_lower |=> unicast_lower_r == $past(wdata)) // see R5
    else $error("lower word not stored");

  // Read of the upper word returns the stored low half
  chk_read_upper: assert property (@(posedge clock) disable iff (srst)
    rd && addr == OFF_UNICAST_ADDR_UPPER |=> rdata[15:0] == $past(unicast_upper_r)) // see R4
    else $error("upper word readback wrong");

  // Read of identifier word 1 keeps id3 high and id2 low
  chk_read_tpw1: assert property (@(posedge clock) disable iff (srst)
    rd && addr == OFF_VLAN_TAG_PROTO_WORD1 |=> rdata == $past({tpid3_r, tpid2_r})) // see R8
    else $error("tpid word 1 readback wrong");

  // Holes in the map read zero even with the strobe high
  chk_read_unmapped: assert property (@(posedge clock) disable iff (srst)
    rd && addr != OFF_UNICAST_ADDR_LOWER && addr != OFF_UNICAST_ADDR_UPPER &&
    addr != OFF_VLAN_TAG_PROTO_WORD0 && addr != OFF_VLAN_TAG_PROTO_WORD1 &&
    addr != OFF_SERIAL_LINK_STATUS |=> rdata == 32'h0000_0000) // see R20
    else $error("unmapped read not zero");

  // Match address follows the stored pair when the filter is built
  chk_match_order: assert property (@(posedge clock) disable iff (srst)
    build_ext_multicast_filter |=> unicast_match_address == $past(full_addr)) // see R5
    else $error("match address order wrong");

  // Without the filter the address plays no part
  chk_match_unbuilt: assert property (@(posedge clock) disable iff (srst)
    !build_ext_multicast_filter |=> unicast_match_address == 48'h0000_0000_0000) // see R1
    else $error("match address live without filter");

  // Multicast and broadcast are left to other logic, never dropped here
  chk_no_drop_mcast: assert property (@(posedge clock) disable iff (srst)
    rx_dest.valid && !rx_dest.is_unicast |=> !rx_drop) // see R3
    else $error("non-unicast frame dropped");

  // Drop is a one-cycle answer to a probe, never spontaneous
  chk_drop_idle: assert property (@(posedge clock) disable iff (srst)
    !rx_dest.valid |=> !rx_drop) // see R3
    else $error("drop without probe");

  // Identifier bus keeps id3..id0 order for both paths
  chk_ids_order: assert property (@(posedge clock) disable iff (srst)
    vlan_built |=> tag_proto_ids == $past({tpid3_r, tpid2_r, vlan_tag_proto_word1_r, vlan_tag_proto_word0_r})) // see R6
    else $error("identifier bus order wrong");

  // With no VLAN function the identifiers stay quiet
  chk_ids_unbuilt: assert property (@(posedge clock) disable iff (srst)
    !vlan_built |=> tag_proto_ids == 64'h0000_0000_0000_0000) // see R9
    else $error("identifiers live without VLAN function");

  // Valid flag settles to the build choice one cycle after reset
  chk_ids_valid: assert property (@(posedge clock) disable iff (srst)
    1'b1 |=> tag_proto_ids_valid == vlan_built) // see R9
    else $error("identifier valid flag wrong");

  // Unsupported builds read all zeros
  chk_status_dead: assert property (@(posedge clock) disable iff (srst)
    !status_live |=> status_r == 32'h0000_0000) // see R10
    else $error("status live in unsupported build");

  // Duplex bit follows the PCS
  chk_duplex_bit: assert property (@(posedge clock) disable iff (srst)
    status_live |=> status_r[POS_DUPLEX] == $past(pcs_status.full_duplex)) // see R13
    else $error("duplex bit not tracking");

  // Fault code follows the PCS in 1000BASE-X
  chk_fault_code: assert property (@(posedge clock) disable iff (srst)
    status_live && is_basex
    |=> status_r[POS_FAULT_CODE_LO +: 2] == $past(pcs_status.remote_fault_code)) // see R15
    else $error("fault code not tracking");

  // Fault flag means nothing in SGMII, so it is held low there
  chk_sgmii_fault: assert property (@(posedge clock) disable iff (srst)
    !is_basex |=> !status_r[POS_REMOTE_FAULT]) // see R11
    else $error("fault flag set outside 1000BASE-X");

  // Link bit follows the external PHY in SGMII
  chk_link_sgmii: assert property (@(posedge clock) disable iff (srst)
    status_live && !is_basex
    |=> status_r[POS_PHY_LINK] == $past(pcs_status.external_phy_link_up)) // see R16
    else $error("phy link bit not tracking");

  // Code group error bit follows the decoder
  chk_unknown_cg: assert property (@(posedge clock) disable iff (srst)
    status_live |=> status_r[POS_UNKNOWN_CG] == $past(pcs_status.rx_unknown_code_group)) // see R17
    else $error("unknown code group bit not tracking");

  // Disparity error bit follows the decoder
  chk_disp_err: assert property (@(posedge clock) disable iff (srst)
    status_live
    |=> status_r[POS_DISP_ERR] == $past(pcs_status.rx_running_disparity_error)) // see R18
    else $error("disparity error bit not tracking");

  // Management read clears the flag when no new fault lands in the same cycle
  chk_fault_clear: assert property (@(posedge clock) disable iff (srst)
    remote_fault_r && mgmt_status_read && !fault_event |=> !remote_fault_r) // see R12
    else $error("remote fault flag not cleared");

endmodule

// file: sim/testbench.sv
// Self-checking bench for the filter, VLAN protocol and link status register bank.
// Assumes the default build: extended filter, one VLAN function, 1000BASE-X link.
`timescale 1ns/100ps
module testbench;
  import filt_vlan_stat_pkg::*;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  pcs_status_t pcs_status = '0;
  logic mgmt_status_read = 1'b0;
  rx_dest_t rx_dest = '0;
  logic rx_drop;
  logic [47:0] unicast_match_address;
  logic [63:0] tag_proto_ids;
  logic tag_proto_ids_valid;
  int fail_count = 0;
  int checks = 0;
  logic [DATA_W-1:0] got;
  logic [1:0] spd_list [3] = '{SPEED_1000, SPEED_100, SPEED_10};

  // One comparison: counts it, reports a mismatch at once
  `define CHK(what, exp, seen) \
    checks++; \
    if ((seen) !== (exp)) \
    begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", what, exp, seen); \
    end

  // 5 ns period for 200 MHz
  always #2.5 clock = ~clock;

  filt_vlan_stat_regs filt_vlan_stat_regs_inst (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pcs_status(pcs_status), .mgmt_status_read(mgmt_status_read),
    .rx_dest(rx_dest), .rx_drop(rx_drop), .unicast_match_address(unicast_match_address),
    .tag_proto_ids(tag_proto_ids), .tag_proto_ids_valid(tag_proto_ids_valid)
  );

  // Bus cycles: strobe held one cycle, read data sampled just after the next edge
  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic read_check(input string what, input logic [11:0] a, input logic [31:0] e);
    reg_read(a, got);
    `CHK(what, e, got)
  endtask

  // One probe cycle; the drop decision appears right after the following edge
  task automatic probe(input logic uni, input logic [47:0] da, input logic exp_drop);
    @(posedge clock);
    rx_dest <= '{valid: 1'b1, is_unicast: uni, dest_addr: da};
    @(posedge clock);
    rx_dest <= '0;
    #1;
    `CHK("rx_drop", exp_drop, rx_drop)
  endtask

  // Status word as the bank should present it in a 1000BASE-X build (link bit held low)
  function automatic logic [31:0] stat_exp(logic f, logic dup, logic [1:0] spd, logic [1:0] c,
                                           logic unk, logic disp);
    return {18'h0_0000, f, dup, spd, c, 1'b0, unk, disp, 5'h00};
  endfunction

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the sequence needs about 70 cycles, so 3000 is ample
  initial
  begin
    repeat (3000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    read_check("upper_rst", OFF_UNICAST_ADDR_UPPER, 32'h0000_0000);
    read_check("vlan_tag_proto_word0_rst", OFF_VLAN_TAG_PROTO_WORD0, 32'h0000_0000);
    read_check("vlan_tag_proto_word1_rst", OFF_VLAN_TAG_PROTO_WORD1, 32'h0000_0000);
    read_check("status_rst", OFF_SERIAL_LINK_STATUS, 32'h0000_0000);
    // Reserved upper half must ignore ones
    reg_write(OFF_UNICAST_ADDR_UPPER, 32'hffff_eeff);
    read_check("upper_rsvd", OFF_UNICAST_ADDR_UPPER, 32'h0000_eeff);
    reg_write(OFF_UNICAST_ADDR_LOWER, 32'hddcc_bbaa);
    reg_write(OFF_UNICAST_ADDR_UPPER, 32'h0000_ffee);
    // Match address is registered once more after the write lands
    @(posedge clock);
    #1;
    `CHK("match_addr", 48'hffee_ddcc_bbaa, unicast_match_address)
    // Core filter is taken as promiscuous, so every unicast reaches this bank
    probe(1'b1, 48'hffee_ddcc_bbaa, 1'b0);
    probe(1'b1, 48'hffee_ddcc_bbab, 1'b1);
    probe(1'b0, 48'h0000_0000_0001, 1'b0);
    // Identifier words, each half distinct so a swap shows
    reg_write(OFF_VLAN_TAG_PROTO_WORD0, 32'h9100_8100);
    reg_write(OFF_VLAN_TAG_PROTO_WORD1, 32'h88a8_9200);
    read_check("vlan_tag_proto_word0", OFF_VLAN_TAG_PROTO_WORD0, 32'h9100_8100);
    read_check("vlan_tag_proto_word1", OFF_VLAN_TAG_PROTO_WORD1, 32'h88a8_9200);
    `CHK("tag_ids", 64'h88a8_9200_9100_8100, tag_proto_ids)
    `CHK("tag_valid", 1'b1, tag_proto_ids_valid)
    // Status is read-only and the hole past it reads zero
    reg_write(OFF_SERIAL_LINK_STATUS, 32'hffff_ffff);
    read_check("status_ro", OFF_SERIAL_LINK_STATUS, 32'h0000_0000);
    reg_write(12'h040, 32'h1234_5678);
    read_check("unmapped", 12'h040, 32'h0000_0000);
    // Each speed code with link level errors; link bit must stay low here
    foreach (spd_list[i])
    begin
      pcs_status <= '{remote_fault_event: 1'b0, remote_fault_code: 2'h0, full_duplex: 1'b1,
                      speed: spd_list[i],
                      external_phy_link_up: 1'b1, rx_unknown_code_group: i[0],
                      rx_running_disparity_error: ~i[0]};
      repeat (3) @(posedge clock);
      read_check("status_live", OFF_SERIAL_LINK_STATUS,
                 stat_exp(1'b0, 1'b1, spd_list[i],
                          2'h0, i[0], ~i[0]));
    end
    // One-cycle fault event must be held until the management read
    @(posedge clock);
    pcs_status <= '{1'b1, 2'h3, 1'b1, SPEED_1000, 1'b0, 1'b0, 1'b0};
    @(posedge clock);
    pcs_status.remote_fault_event <= 1'b0;
    repeat (4) @(posedge clock);
    read_check("fault_held", OFF_SERIAL_LINK_STATUS,
               stat_exp(1'b1, 1'b1, SPEED_1000, 2'h3, 1'b0, 1'b0));
    @(posedge clock);
    mgmt_status_read <= 1'b1;
    @(posedge clock);
    mgmt_status_read <= 1'b0;
    repeat (3) @(posedge clock);
    reg_read(OFF_SERIAL_LINK_STATUS, got);
    `CHK("fault_clear", 1'b0, got[POS_REMOTE_FAULT])
    tally_and_finish();
  end
endmodule
